// File: itp_arbiter.sv
// Combinational selection of the winning user interrupt source.
// Assumes flags, enables and priorities come straight from registers.
`timescale 1ns/10ps
`include "itp_regs.svh"

module itp_arbiter (
   input wire logic [`ITP_NSRC-1:0] flag,
   input wire logic [`ITP_NSRC-1:0] ena,
   input wire itp_pkg::itp_prio_t prio,
   input wire logic [3:0] cpuLevel,
   output logic winValid,
   output logic [6:0] winIndex,
   output logic [3:0] winLevel
);

   ////////////////////////////////////////////////////////////////////////////
   // Ascending scan with a strict compare, so a tie keeps the lower index.
   always_comb begin
      logic [3:0] best;
      best = cpuLevel;
      winValid = 1'b0;
      winIndex = 7'h00;
      winLevel = 4'h0;
      for (int i = 0; i < `ITP_NSRC; i++) begin
         if (flag[i] && ena[i] && ({1'b0, prio[i]} > best)) begin
            best = {1'b0, prio[i]};
            winValid = 1'b1;
            winIndex = 7'(i);
            winLevel = {1'b0, prio[i]};
         end
      end
   end

endmodule // itp_arbiter

// File: itp_cpu_model.sv
// CPU core model: acknowledges a presented interrupt after a set wait.
// Assumes the controller's clock, reset and request output.
`timescale 1ns/10ps

module itp_cpu_model (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic irqReq,
   input wire logic ackOn,
   input wire logic [1:0] ackWait,
   output logic cpuAck
);
   logic [1:0] cnt;

   // Count cycles of a shown request; the ack is one cycle so it is never taken twice.
   always_ff @(posedge mclk) begin
      if (!rstn || !irqReq || cpuAck) begin
         cnt <= 2'h0;
         cpuAck <= 1'b0;
      end else begin
         cnt <= cnt + 2'h1;
         cpuAck <= ackOn && (cnt == ackWait);
      end
   end
endmodule // itp_cpu_model

// File: itp_ctrl.sv
// Interrupt and trap priority controller with its APB register file.
// Assumes one clock, peripheral request pulses and pins synchronous to it.
`timescale 1ns/10ps
`include "itp_regs.svh"

module itp_ctrl (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`ITP_NSRC-1:0] srcReq,
   input wire logic [`ITP_NEXT-1:0] extPin,
   input wire logic oscFailReq,
   input wire logic addrErrReq,
   input wire logic stackErrReq,
   input wire logic mathErrReq,
   input wire logic dmaErrReq,
   input wire logic cpuAck,
   input wire logic cpuRestore,
   input wire logic [3:0] restoreLevel,
   output logic irqReq,
   output logic [6:0] irqVector,
   output logic [3:0] irqLevel,
   output logic [23:0] irqAddr
);

   itp_pkg::itp_state_t s_q;
   itp_pkg::itp_state_t s_d;
   logic [3:0] curLevel;
   logic userValid;
   logic [6:0] userIndex;
   logic [3:0] userLevel;
   logic [`ITP_NSRC-1:0] extSet;
   logic [`ITP_NEXT-1:0] extEdge;
   logic [6:0] extSrc [`ITP_NEXT];
   logic [15:0] trapSet;
   logic [5:0] regIdx;
   logic setupPhase;
   logic wrTake;

   ////////////////////////////////////////////////////////////////////////////
   // Current CPU level is the top bit joined above the 3-bit field.
   assign curLevel = {s_q.cpuTop, s_q.cpuLevel};
   assign regIdx = paddr[7:2];
   assign setupPhase = psel && !penable;
   // A write lands only on the access edge where our ready is high.
   assign wrTake = psel && penable && s_q.pready && pwrite;

   // Every output is a straight copy of a state flop.
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irqReq = s_q.irqReq;
   assign irqVector = s_q.irqVector;
   assign irqLevel = s_q.irqLevel;
   assign irqAddr = s_q.irqAddr;

   ////////////////////////////////////////////////////////////////////////////
   // User source selection; the level compare also does the CPU-level masking.
   itp_arbiter uArb (
      .flag(s_q.flag),
      .ena(s_q.ena),
      .prio(s_q.prio),
      .cpuLevel(curLevel),
      .winValid(userValid),
      .winIndex(userIndex),
      .winLevel(userLevel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // External pins: per-pin edge polarity from the second global register.
   assign extSrc[0] = `ITP_EXT0_SRC;
   assign extSrc[1] = `ITP_EXT1_SRC;
   assign extSrc[2] = `ITP_EXT2_SRC;
   assign extSrc[3] = `ITP_EXT3_SRC;
   assign extSrc[4] = `ITP_EXT4_SRC;

   genvar gE;
   generate
      for (gE = 0; gE < `ITP_NEXT; gE++) begin : gExt
         // Bit set selects the falling edge, clear selects the rising edge.
         assign extEdge[gE] = s_q.gctrl2[gE] ? (s_q.extPrev[gE] && !extPin[gE])
                                            : (!s_q.extPrev[gE] && extPin[gE]);
      end
   endgenerate

   // Fold the pin edges into the flag-set vector at the source positions given by extSrc.
   always_comb begin
      extSet = srcReq;
      for (int k = 0; k < `ITP_NEXT; k++) begin
         if (extEdge[k]) begin
            extSet[extSrc[k]] = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trap requests placed at their flag positions in the first global register.
   always_comb begin
      trapSet = 16'h0000;
      trapSet[`ITP_TRAP_OSC] = oscFailReq;
      trapSet[`ITP_TRAP_ADDR] = addrErrReq;
      trapSet[`ITP_TRAP_STACK] = stackErrReq;
      trapSet[`ITP_TRAP_MATH] = mathErrReq;
      trapSet[`ITP_TRAP_DMA] = dmaErrReq;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register map, one 16-bit register per 32-bit word; upper bits read 0.
   // Word 0 is the first global control register.
   //    Bit 15 is the nesting disable; bits 14 to 1 hold trap flags and controls.
   //    Bit 0 is not implemented and always reads 0.
   // Word 1 is the second global control register.
   //    Bit 15 selects the alternate vector table.
   //    Bits 4 to 0 pick the active edge of each external pin, 1 for falling.
   // Words 2 to 6 hold the request flags, sixteen sources to a word.
   //    Source 0 sits at bit 0 of word 2, and flags 72 to 79 read 0.
   //    A write stores the value, so writing 0 clears and writing 1 sets.
   // Words 7 to 11 hold the enables in the same layout as the flags.
   // Words 12 to 29 hold the priorities, four sources to a word.
   //    Fields sit at bits 2:0, 6:4, 10:8 and 14:12, and the gaps read 0.
   // Word 30 is the pending vector register, which ignores writes.
   //    Bits 6:0 carry the vector number and bits 11:8 its level.
   // Word 31 is the CPU status register.
   //    Bits 7:5 carry the low three bits of the CPU level; the rest read 0.
   // Word 32 is the core control register.
   //    Bit 3 is the top level bit, which software cannot write.
   //    The other bits are plain storage behind a write mask.
   // Every other word answers with a slave error and no data.

   ////////////////////////////////////////////////////////////////////////////
   // Bus timing, with no wait states.
   // At the setup edge, read data, ready and error are registered from the address.
   // At the access edge, ready is seen high, a write lands and the master takes data.
   // The access edge also registers ready and data back to 0.
   // A new setup may follow the access at once, so transfers can run back to back.

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt timing.
   // A request that is high before edge N sets its flag at edge N.
   // The winner is registered on the request outputs at edge N+1.
   // An acknowledge at edge M loads the CPU level from the level shown.
   // The request falls at edge M+1 unless something higher still waits.

   ////////////////////////////////////////////////////////////////////////////
   // Hazards and limits worth knowing before this block is changed.
   // Read data is caught at the setup edge, so a flag set during the access
   // cycle shows up only on the next read.
   // A flag write replaces the whole word, so software must read, modify and
   // write back to clear one flag without losing a fresh one.
   // Hardware sets are applied after a software write in the same cycle,
   // so a request that arrives with the clearing write is kept.
   // A pin edge and a flag write in one cycle also keep the edge.
   // Trap flags stay set until software clears them, so a trap is offered
   // again as soon as the CPU level falls below its level.
   // The top level bit moves only through the acknowledge and restore inputs,
   // which keeps traps beyond the reach of software masking.
   // The external pins are taken as synchronous; a pin from outside the chip
   // needs a synchroniser in front of this block.
   // Traps are ranked by vector number alone, the lowest vector first.
   // The pending vector register holds its last value when nothing waits.
   // The vector address is the table base plus twice the vector number.

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: register file, flags, CPU level and the CPU request.
   always_comb begin
      logic [16*`ITP_NFLAGREG-1:0] flagWide;
      logic [16*`ITP_NFLAGREG-1:0] enaWide;
      logic [2:0] trapVec;
      logic trapValid;
      logic [3:0] trapLevel;
      logic candValid;
      logic [6:0] candVec;
      logic [3:0] candLevel;
      logic [23:0] tableBase;
      logic [31:0] rd;
      logic hit;
      flagWide = {{(16*`ITP_NFLAGREG-`ITP_NSRC){1'b0}}, s_q.flag};
      enaWide = {{(16*`ITP_NFLAGREG-`ITP_NSRC){1'b0}}, s_q.ena};
      trapVec = 3'h0;
      trapValid = 1'b0;
      trapLevel = 4'h0;
      candValid = 1'b0;
      candVec = 7'h00;
      candLevel = 4'h0;
      tableBase = `ITP_PRI_TABLE_BASE;
      rd = 32'h0000_0000;
      hit = 1'b1;
      s_d = s_q;
      s_d.extPrev = extPin;

      // Read data is caught in the setup cycle and shown during the access.
      if (regIdx == `ITP_IDX_GCTRL1) begin
         rd[15:0] = s_q.gctrl1;
      end else if (regIdx == `ITP_IDX_GCTRL2) begin
         rd[15:0] = s_q.gctrl2;
      end else if (regIdx >= `ITP_IDX_FLAG0 && regIdx < `ITP_IDX_ENA0) begin
         rd[15:0] = flagWide[(regIdx - `ITP_IDX_FLAG0) * 16 +: 16];
      end else if (regIdx >= `ITP_IDX_ENA0 && regIdx < `ITP_IDX_PRIO0) begin
         rd[15:0] = enaWide[(regIdx - `ITP_IDX_ENA0) * 16 +: 16];
      end else if (regIdx >= `ITP_IDX_PRIO0 && regIdx < `ITP_IDX_PENDVEC) begin
         for (int f = 0; f < 4; f++) begin
            rd[4*f +: 3] = s_q.prio[(regIdx - `ITP_IDX_PRIO0) * 4 + f];
         end
      end else if (regIdx == `ITP_IDX_PENDVEC) begin
         rd[6:0] = s_q.pending_vector_number;
         rd[11:8] = s_q.pendLevel;
      end else if (regIdx == `ITP_IDX_CPUSTAT) begin
         rd[`ITP_CS_LEVEL_LSB +: 3] = s_q.cpuLevel;
      end else if (regIdx == `ITP_IDX_CORECTL) begin
         rd[15:0] = s_q.coreStore;
         rd[`ITP_CC_TOPBIT] = s_q.cpuTop;
      end else begin
         hit = 1'b0;
      end

      // Zero wait states: ready rises for exactly the first access cycle.
      if (setupPhase) begin
         s_d.pready = 1'b1;
         s_d.prdata = pwrite ? 32'h0000_0000 : rd;
         s_d.pslverr = !hit;
      end else begin
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
         s_d.prdata = 32'h0000_0000;
      end

      // Software writes; read-only words drop writes silently, unmapped words with a slave error.
      if (wrTake) begin
         if (regIdx == `ITP_IDX_GCTRL1) begin
            s_d.gctrl1 = pwdata[15:0] & `ITP_G1_WMASK;
         end else if (regIdx == `ITP_IDX_GCTRL2) begin
            s_d.gctrl2 = pwdata[15:0] & `ITP_G2_WMASK;
         end else if (regIdx >= `ITP_IDX_FLAG0 && regIdx < `ITP_IDX_ENA0) begin
            flagWide[(regIdx - `ITP_IDX_FLAG0) * 16 +: 16] = pwdata[15:0];
         end else if (regIdx >= `ITP_IDX_ENA0 && regIdx < `ITP_IDX_PRIO0) begin
            enaWide[(regIdx - `ITP_IDX_ENA0) * 16 +: 16] = pwdata[15:0];
         end else if (regIdx >= `ITP_IDX_PRIO0 && regIdx < `ITP_IDX_PENDVEC) begin
            for (int f = 0; f < 4; f++) begin
               s_d.prio[(regIdx - `ITP_IDX_PRIO0) * 4 + f] = pwdata[4*f +: 3];
            end
         end else if (regIdx == `ITP_IDX_CPUSTAT) begin
            // Nesting disable freezes the field against software only.
            if (!s_q.gctrl1[`ITP_G1_NESTDIS]) begin
               s_d.cpuLevel = pwdata[`ITP_CS_LEVEL_LSB +: 3];
            end
         end else if (regIdx == `ITP_IDX_CORECTL) begin
            // The top level bit is outside the write mask on purpose.
            s_d.coreStore = pwdata[15:0] & `ITP_CC_WMASK;
         end
      end

      // Hardware sets after the software write, so a same-cycle set wins.
      s_d.flag = flagWide[`ITP_NSRC-1:0] | extSet;
      s_d.ena = enaWide[`ITP_NSRC-1:0];
      s_d.gctrl1 = s_d.gctrl1 | trapSet;

      // Traps: the lowest vector wins and every trap level sits above 7.
      for (int v = `ITP_TRAP_DMA; v >= `ITP_TRAP_OSC; v--) begin
         if (s_q.gctrl1[v]) begin
            trapVec = 3'(v);
         end
      end
      trapLevel = `ITP_TRAP_LEVEL_TOP - {1'b0, trapVec};
      trapValid = (trapVec != 3'h0) && (trapLevel > curLevel);

      // Traps outrank every user source, whose levels stop at 7.
      if (trapValid) begin
         candValid = 1'b1;
         candVec = {4'h0, trapVec};
         candLevel = trapLevel;
      end else if (userValid) begin
         candValid = 1'b1;
         candVec = `ITP_FIRST_USER_VEC + userIndex;
         candLevel = userLevel;
      end

      // Pending register tracks the current winner and holds when none.
      if (candValid) begin
         s_d.pending_vector_number = candVec;
         s_d.pendLevel = candLevel;
      end

      // Vector address from the primary or alternate table.
      if (s_q.gctrl2[`ITP_G2_ALTTABLE]) begin
         tableBase = `ITP_ALT_TABLE_BASE;
      end
      s_d.irqReq = candValid;
      s_d.irqVector = candVec;
      s_d.irqLevel = candLevel;
      s_d.irqAddr = tableBase + {16'h0000, candVec, 1'b0};

      // Taking an interrupt raises the CPU level to the one it carried;
      // hardware may also lower the top bit when the CPU returns.
      if (cpuAck && s_q.irqReq) begin
         s_d.cpuTop = s_q.irqLevel[3];
         s_d.cpuLevel = s_q.irqLevel[2:0];
      end else if (cpuRestore) begin
         s_d.cpuTop = restoreLevel[3];
         s_d.cpuLevel = restoreLevel[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; every field clears except the saturate-write default.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.coreStore <= `ITP_CC_RESET;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // itp_ctrl

// File: itp_ctrl_asserts.sv
// Checker for the interrupt and trap priority controller.
// Assumes it is bound to itp_ctrl and sees its ports only.
`timescale 1ns/10ps
`include "itp_regs.svh"

module itp_ctrl_chk (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cpuAck,
   input wire logic cpuRestore,
   input wire logic [3:0] restoreLevel,
   input wire logic irqReq,
   input wire logic [6:0] irqVector,
   input wire logic [3:0] irqLevel,
   input wire logic [23:0] irqAddr
);
   // Every check runs on the core clock, quiet while reset is low.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   a_data_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_vec_reserved: assert property (irqReq |-> !(irqVector inside {7'h00, 7'h06, 7'h07}))
      else $error("reserved vector presented");
   a_trap_level: assert property (irqReq && irqVector < 7'h08
      |-> irqLevel == 4'hF - irqVector[3:0])
      else $error("trap level wrong");
   a_user_level: assert property (irqReq && irqVector >= 7'h08 |-> irqLevel <= 4'h7)
      else $error("user level above seven");
   a_vec_addr: assert property (irqReq |-> irqAddr == {16'h0, irqVector, 1'b0} + 24'h4
      || irqAddr == {16'h0, irqVector, 1'b0} + 24'h104)
      else $error("vector address wrong");
   // A level of seven or more, top bit included, must hide every user source.
   a_high_blocks: assert property (cpuRestore && restoreLevel >= 4'h7 ##1 !cpuRestore
      && !cpuAck |=> !irqReq || irqVector < 7'h08)
      else $error("user source shown at high level");
   a_ack_drop: assert property (cpuAck && irqReq
      |=> ##1 !irqReq || irqLevel > $past(irqLevel, 2))
      else $error("request stayed after ack");
endmodule // itp_ctrl_chk

// File: itp_pkg.sv
// Types shared by the interrupt and trap priority controller.
// Assumes itp_regs.svh is on the include path.
`include "itp_regs.svh"

package itp_pkg;

   // One 3-bit priority per user source, index equals natural order.
   typedef logic [`ITP_NSRC-1:0][2:0] itp_prio_t;

   // Whole state of the controller, registered as one word.
   typedef struct packed {
      logic [15:0] gctrl1;
      logic [15:0] gctrl2;
      logic [`ITP_NSRC-1:0] flag;
      logic [`ITP_NSRC-1:0] ena;
      itp_prio_t prio;
      logic [6:0] pending_vector_number;
      logic [3:0] pendLevel;
      logic [2:0] cpuLevel;
      logic cpuTop;
      logic [15:0] coreStore;
      logic [`ITP_NEXT-1:0] extPrev;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irqReq;
      logic [6:0] irqVector;
      logic [3:0] irqLevel;
      logic [23:0] irqAddr;
   } itp_state_t;

endpackage

// File: itp_regs.svh
// Register map, field positions, reset values and fixed vector numbers
// of the interrupt and trap priority controller.
// Assumes a byte-addressed APB slave with one 32-bit word per register.
`ifndef ITP_REGS_SVH
`define ITP_REGS_SVH

// Source counts and widths.
`define ITP_NSRC 72
`define ITP_NFLAGREG 5
`define ITP_NPRIOREG 18
`define ITP_NEXT 5
`define ITP_FIRST_USER_VEC 7'h08

// Word indices; the byte address is four times the index.
`define ITP_IDX_GCTRL1 6'h00
`define ITP_IDX_GCTRL2 6'h01
`define ITP_IDX_FLAG0 6'h02
`define ITP_IDX_ENA0 6'h07
`define ITP_IDX_PRIO0 6'h0C
`define ITP_IDX_PENDVEC 6'h1E
`define ITP_IDX_CPUSTAT 6'h1F
`define ITP_IDX_CORECTL 6'h20

// First global control register fields.
`define ITP_G1_NESTDIS 15
`define ITP_G1_WMASK 16'hFFFE
`define ITP_TRAP_OSC 1
`define ITP_TRAP_ADDR 2
`define ITP_TRAP_STACK 3
`define ITP_TRAP_MATH 4
`define ITP_TRAP_DMA 5
`define ITP_TRAP_LEVEL_TOP 4'hF

// Second global control register fields.
`define ITP_G2_ALTTABLE 15
`define ITP_G2_WMASK 16'h801F

// CPU status and core control fields.
`define ITP_CS_LEVEL_LSB 5
`define ITP_CC_TOPBIT 3
`define ITP_CC_WMASK 16'h18F7
`define ITP_CC_RESET 16'h0020

// Vector tables, word addresses of vector 0.
`define ITP_PRI_TABLE_BASE 24'h000004
`define ITP_ALT_TABLE_BASE 24'h000104

// User source index of each external request pin.
`define ITP_EXT0_SRC 7'd0
`define ITP_EXT1_SRC 7'd20
`define ITP_EXT2_SRC 7'd29
`define ITP_EXT3_SRC 7'd53
`define ITP_EXT4_SRC 7'd54

`endif

// File: tb.sv
// Top testbench: APB register tests and interrupt presentation tests.
// Assumes itp_ctrl, its checker and the CPU model are compiled first.
`timescale 1ns/10ps
`include "itp_regs.svh"

module tb;
   logic mclk = 1'b0;
   logic rstn, psel, penable, pwrite, cpuRestore, ackOn, cpuAck, erv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic pready, pslverr, irqReq;
   logic [`ITP_NSRC-1:0] srcReq;
   logic [4:0] extPin, trap;
   logic [3:0] restoreLevel, irqLevel;
   logic [1:0] ackWait;
   logic [6:0] irqVector;
   logic [23:0] irqAddr;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   itp_ctrl i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .srcReq(srcReq), .extPin(extPin), .oscFailReq(trap[0]), .addrErrReq(trap[1]),
      .stackErrReq(trap[2]), .mathErrReq(trap[3]), .dmaErrReq(trap[4]), .cpuAck(cpuAck),
      .cpuRestore(cpuRestore), .restoreLevel(restoreLevel), .irqReq(irqReq),
      .irqVector(irqVector), .irqLevel(irqLevel), .irqAddr(irqAddr));
   itp_cpu_model i_cpu (.mclk(mclk), .rstn(rstn), .irqReq(irqReq), .ackOn(ackOn),
      .ackWait(ackWait), .cpuAck(cpuAck));

   // Clock of 5 ns.
   always #2.5 mclk = ~mclk;

   ////////////////////////////////////////
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Cut a hang short well past the expected run of a few hundred cycles.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; an idle edge at the end keeps psel from being driven twice.
   task automatic apb(input logic w, input logic [5:0] i, input logic [15:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= {16'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for ready.
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [5:0] i, input logic [15:0] d);
      apb(1'b1, i, d);
   endtask

   task automatic rc(input logic [5:0] i, input logic [31:0] e);
      apb(1'b0, i, 16'h0);
      cmp("register", e, rdv);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic irq(input logic [6:0] v, input logic [3:0] l, input logic [23:0] a);
      int n;
      n = 0;
      while (irqReq !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      cmp("request", 32'h1, {31'h0, irqReq});
      cmp("vector", {25'h0, v}, {25'h0, irqVector});
      cmp("level", {28'h0, l}, {28'h0, irqLevel});
      cmp("address", {8'h0, a}, {8'h0, irqAddr});
   endtask

   task automatic pulse(input logic [`ITP_NSRC-1:0] m);
      srcReq <= m;
      @(posedge mclk);
      srcReq <= '0;
   endtask

   task automatic restore(input logic [3:0] l);
      cpuRestore <= 1'b1;
      restoreLevel <= l;
      @(posedge mclk);
      cpuRestore <= 1'b0;
   endtask

   ////////////////////////////////////////
   // Main sequence: reset, register access, user sources, then traps.
   initial begin
      {rstn, psel, penable, pwrite, cpuRestore, ackOn} <= 6'h00;
      {paddr, pwdata, srcReq, extPin, trap, restoreLevel} <= '0;
      ackWait <= 2'h2;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rc(6'h1F, 32'h0);
      rc(6'h20, 32'h20);
      apb(1'b0, 6'h3F, 16'h0);
      cmp("slave error", 32'h1, {31'h0, erv});
      $display("test reset done");
      wr(6'h1F, 16'hFFFF);
      rc(6'h1F, 32'hE0);
      wr(6'h20, 16'hFFFF);
      rc(6'h20, 32'h18F7);
      wr(6'h00, 16'h8000);
      wr(6'h1F, 16'h0040);
      rc(6'h1F, 32'hE0);
      wr(6'h00, 16'h0000);
      wr(6'h1F, 16'h0000);
      rc(6'h1F, 32'h0);
      $display("test level field done");
      wr(6'h0C, 16'h0003);
      pulse(72'h1);
      rc(6'h02, 32'h1);
      idle(4);
      cmp("request", 32'h0, {31'h0, irqReq});
      ackOn <= 1'b1;
      wr(6'h07, 16'h0001);
      irq(7'h08, 4'h3, 24'h14);
      rc(6'h1E, 32'h0308);
      idle(4);
      cmp("request", 32'h0, {31'h0, irqReq});
      ackOn <= 1'b0;
      rc(6'h1F, 32'h60);
      rc(6'h02, 32'h1);
      wr(6'h02, 16'h0);
      rc(6'h02, 32'h0);
      wr(6'h1F, 16'h0);
      $display("test single source done");
      wr(6'h0C, 16'h0550);
      wr(6'h07, 16'h0006);
      pulse(72'h6);
      irq(7'h09, 4'h5, 24'h16);
      wr(6'h1F, 16'h00A0);
      idle(3);
      cmp("request", 32'h0, {31'h0, irqReq});
      restore(4'h8);
      rc(6'h20, 32'h18FF);
      cmp("request", 32'h0, {31'h0, irqReq});
      restore(4'h0);
      irq(7'h09, 4'h5, 24'h16);
      wr(6'h0C, 16'h0770);
      restore(4'h7);
      idle(3);
      cmp("request", 32'h0, {31'h0, irqReq});
      restore(4'h6);
      irq(7'h09, 4'h7, 24'h16);
      wr(6'h07, 16'h0);
      $display("test priority done");
      wr(6'h02, 16'h0);
      wr(6'h01, 16'h0002);
      extPin <= 5'h03;
      idle(1);
      rc(6'h03, 32'h0);
      extPin <= 5'h01;
      idle(1);
      rc(6'h02, 32'h1);
      rc(6'h03, 32'h10);
      extPin <= 5'h00;
      $display("test external pins done");
      for (int v = 1; v <= 5; v++) begin
         wr(6'h01, {v[0], 15'h0});
         trap <= 5'(1 << (v - 1));
         @(posedge mclk);
         trap <= 5'h0;
         irq(7'(v), 4'(15 - v), (v[0] ? 24'h104 : 24'h4) + 24'(2 * v));
         rc(6'h00, 32'(1 << v));
         wr(6'h00, 16'h0);
      end
      $display("test traps done");
      wrap_up();
   end
endmodule // tb

bind itp_ctrl itp_ctrl_chk i_chk (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuAck(cpuAck),
   .cpuRestore(cpuRestore), .restoreLevel(restoreLevel), .irqReq(irqReq),
   .irqVector(irqVector), .irqLevel(irqLevel), .irqAddr(irqAddr));
